//--- core/usb_link_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_link_regs.svh"

module usb_link_ctrl
  import usb_link_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Role and line events from the link logic.
  input wire logic host_role,
  input wire logic bus_idle_event,
  input wire logic bus_activity,
  // Token address decode.
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  output logic token_match,
  // Link control and status.
  output logic resume_drive,
  output logic suspend_state_flag,
  output logic [6:0] device_function_addr,
  output logic [15:0] rx_fifo_byte_addr,
  output logic [15:0] tx_fifo_byte_addr
);

  ctrl_state_t st_q;
  ctrl_state_t st_d;
  logic req;
  logic wr_acc;
  logic csr_wr;
  logic fifo_wr;
  logic set_hw;
  logic set_sw;
  logic clr_hw;

  // Every access waits exactly one cycle so read data can be registered.
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !st_q.ack;
  assign wr_acc = avs_write && st_q.ack;
  assign csr_wr = wr_acc && (avs_address == `CSR0_OFS);
  assign fifo_wr = wr_acc && (avs_address == `FIFOA_OFS);

  // Suspend entry needs the enable; device role enters on bus idle,
  // host role enters on a software write.
  assign set_hw = !host_role && st_q.suspend_allow
                  && bus_idle_event;
  assign set_sw = host_role && st_q.suspend_allow && csr_wr
                  && avs_byteenable[1]
                  && avs_writedata[`CSR0_SUSP_FLAG_BIT];
  // Our own resume drive must not count as far-end activity, otherwise
  // suspend would end the moment we start signaling.
  assign clr_hw = (bus_activity && !st_q.resume_ctl)
                  || (st_q.resume_ctl && st_q.suspend_flag && csr_wr
                      && avs_byteenable[1]
                      && !avs_writedata[`CSR0_RESUME_BIT]);

  // Next state of the whole block.
  always_comb begin
    st_d = st_q;
    st_d.ack = req && !st_q.ack;
    if (req && !st_q.ack) begin
      case (avs_address)
        `CSR0_OFS: begin
          st_d.rdata = `RDATA_RST;
          st_d.rdata[`CSR0_DEVICE_FUNCTION_ADDR_MSB:`CSR0_DEVICE_FUNCTION_ADDR_LSB] = st_q.device_function_addr_addr;
          st_d.rdata[`CSR0_RSVD_BIT] = 1'b0;
          st_d.rdata[`CSR0_SUSP_ALLOW_BIT] = st_q.suspend_allow;
          st_d.rdata[`CSR0_SUSP_FLAG_BIT] = st_q.suspend_flag;
          st_d.rdata[`CSR0_RESUME_BIT] = st_q.resume_ctl;
        end
        `FIFOA_OFS: begin
          st_d.rdata = `RDATA_RST;
          st_d.rdata[`FIFOA_RX_MSB:`FIFOA_RX_LSB] = st_q.rx_fifo;
          st_d.rdata[`FIFOA_TX_MSB:`FIFOA_TX_LSB] = st_q.tx_fifo;
        end
        default: begin
          st_d.rdata = `RDATA_RST;
        end
      endcase
    end
    if (csr_wr && avs_byteenable[0]) begin
      st_d.device_function_addr_addr = avs_writedata[`CSR0_DEVICE_FUNCTION_ADDR_MSB:`CSR0_DEVICE_FUNCTION_ADDR_LSB];
    end
    if (csr_wr && avs_byteenable[1]) begin
      st_d.suspend_allow = avs_writedata[`CSR0_SUSP_ALLOW_BIT];
      st_d.resume_ctl = avs_writedata[`CSR0_RESUME_BIT];
    end
    if (fifo_wr && avs_byteenable[0]) begin
      st_d.tx_fifo[7:0] = avs_writedata[7:0];
    end
    if (fifo_wr && avs_byteenable[1]) begin
      st_d.tx_fifo[12:8] = avs_writedata[`FIFOA_TX_MSB:8];
    end
    if (fifo_wr && avs_byteenable[2]) begin
      st_d.rx_fifo[7:0] = avs_writedata[23:16];
    end
    if (fifo_wr && avs_byteenable[3]) begin
      st_d.rx_fifo[12:8] = avs_writedata[`FIFOA_RX_MSB:24];
    end
    // Set wins over clear; in device role software cannot set it, but clearing the resume bit ends it in either role.
    if (set_hw || set_sw) begin
      st_d.suspend_flag = 1'b1;
    end else if (clr_hw) begin
      st_d.suspend_flag = 1'b0;
    end
    st_d.resume_drive = st_d.resume_ctl && st_d.suspend_flag;
  end

  // Single state register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = st_q.rdata;
  assign resume_drive = st_q.resume_drive;
  assign suspend_state_flag = st_q.suspend_flag;
  assign device_function_addr = st_q.device_function_addr_addr;
  assign rx_fifo_byte_addr = {st_q.rx_fifo, 3'h0};
  assign tx_fifo_byte_addr = {st_q.tx_fifo, 3'h0};

  // Tokens are decoded against the stored address only in device role.
  token_addr_match u_match (
    .core_clk(core_clk),
    .rst(rst),
    .match_en(!host_role),
    .token_valid(token_valid),
    .token_addr(token_addr),
    .device_function_addr_addr(st_q.device_function_addr_addr),
    .token_match(token_match)
  );

  property p_resume_start;
    @(posedge core_clk) disable iff (rst)
    (csr_wr && avs_byteenable[1] && avs_writedata[`CSR0_RESUME_BIT]
     && st_q.suspend_flag && !bus_activity) |=> resume_drive;
  endproperty
  a_resume_start: assert property (p_resume_start)
    else $error("Resume signaling did not start after the write.");

  property p_resume_stop;
    @(posedge core_clk) disable iff (rst)
    (csr_wr && avs_byteenable[1] && !avs_writedata[`CSR0_RESUME_BIT])
      |=> !resume_drive [*2];
  endproperty
  a_resume_stop: assert property (p_resume_stop)
    else $error("Resume signaling did not stop after clearing.");

  property p_status_read;
    @(posedge core_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == `CSR0_OFS)
      |-> (avs_readdata[`CSR0_SUSP_FLAG_BIT] == $past(suspend_state_flag));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Suspend status read back wrong.");

  property p_device_ro;
    @(posedge core_clk) disable iff (rst)
    (!host_role && csr_wr && !suspend_state_flag && !bus_idle_event)
      |=> !suspend_state_flag;
  endproperty
  a_device_ro: assert property (p_device_ro)
    else $error("Software changed suspend status in device role.");

  property p_host_set;
    @(posedge core_clk) disable iff (rst)
    set_sw |=> suspend_state_flag;
  endproperty
  a_host_set: assert property (p_host_set)
    else $error("Host software could not set suspend.");

  property p_enable_gate;
    @(posedge core_clk) disable iff (rst)
    (!suspend_state_flag && !st_q.suspend_allow) |=> !suspend_state_flag;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("Suspend entered while suspend was not enabled.");

  property p_device_function_addr_write;
    @(posedge core_clk) disable iff (rst)
    (csr_wr && avs_byteenable[0]) |=>
      (device_function_addr == $past(avs_writedata[6:0]));
  endproperty
  a_device_function_addr_write: assert property (p_device_function_addr_write)
    else $error("Function address not stored.");

  property p_rsvd_zero;
    @(posedge core_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == `CSR0_OFS)
      |-> !avs_readdata[`CSR0_RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved bit 7 read as one.");

  property p_fifo_units;
    @(posedge core_clk) disable iff (rst)
    (fifo_wr && (&avs_byteenable)) |=>
      (rx_fifo_byte_addr == {$past(avs_writedata[28:16]), 3'h0});
  endproperty
  a_fifo_units: assert property (p_fifo_units)
    else $error("Receive FIFO byte address not in eight-byte units.");

endmodule : usb_link_ctrl
`default_nettype wire

//--- core/usb_link_regs.svh
`ifndef USB_LINK_REGS_SVH
`define USB_LINK_REGS_SVH

// Byte offsets of the two registers on the bus.
`define CSR0_OFS 4'h0
`define FIFOA_OFS 4'h4

// Field positions in usb_control_status_zero.
`define CSR0_DEVICE_FUNCTION_ADDR_LSB 0
`define CSR0_DEVICE_FUNCTION_ADDR_MSB 6
`define CSR0_RSVD_BIT 7
`define CSR0_SUSP_ALLOW_BIT 8
`define CSR0_SUSP_FLAG_BIT 9
`define CSR0_RESUME_BIT 10

// Field positions in usb_endpoint_fifo_start.
`define FIFOA_TX_LSB 0
`define FIFOA_TX_MSB 12
`define FIFOA_RX_LSB 16
`define FIFOA_RX_MSB 28

// FIFO start fields count in units of eight bytes.
`define FIFO_UNIT_SHIFT 3

// Reset values.
`define DEVICE_FUNCTION_ADDR_RST 7'h00
`define FIFO_RST 13'h0000
`define RDATA_RST 32'h0000_0000

`endif

//--- core/usb_link_pkg.sv
`default_nettype none
package usb_link_pkg;

  // Whole state of the control and status block.
  typedef struct packed {
    logic [6:0] device_function_addr_addr;
    logic suspend_allow;
    logic suspend_flag;
    logic resume_ctl;
    logic resume_drive;
    logic [12:0] rx_fifo;
    logic [12:0] tx_fifo;
    logic ack;
    logic [31:0] rdata;
  } ctrl_state_t;

  // Whole state of the token address comparator.
  typedef struct packed {
    logic token_match;
  } match_state_t;

endpackage : usb_link_pkg
`default_nettype wire

//--- core/token_addr_match.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_link_regs.svh"

module token_addr_match
  import usb_link_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Comparison inputs.
  input wire logic match_en,
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  input wire logic [6:0] device_function_addr_addr,
  // Result, one cycle after the token.
  output logic token_match
);

  match_state_t st_q;
  match_state_t st_d;

  // A token is ours only when its address equals the stored address.
  always_comb begin
    st_d = st_q;
    st_d.token_match = match_en && token_valid
                       && (token_addr == device_function_addr_addr);
  end

  // Single state register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign token_match = st_q.token_match;

  property p_token_match;
    @(posedge core_clk) disable iff (rst)
    (match_en && token_valid) |=>
      (token_match == ($past(token_addr) == $past(device_function_addr_addr)));
  endproperty
  a_token_match: assert property (p_token_match)
    else $error("Token match does not follow address comparison.");

  property p_no_match_host;
    @(posedge core_clk) disable iff (rst)
    (!match_en || !token_valid) |=> !token_match;
  endproperty
  a_no_match_host: assert property (p_no_match_host)
    else $error("Token matched while matching was disabled.");

endmodule : token_addr_match
`default_nettype wire

//--- tb/link_model.sv
`timescale 1ns/100ps
`default_nettype none
// Link logic model: raises line events and tokens toward the block.
module link_model (
  // Clock.
  input wire logic core_clk,
  // Line events and tokens.
  output logic bus_idle_event,
  output logic bus_activity,
  output logic token_valid,
  output logic [6:0] token_addr
);
  // Quiet at time zero.
  initial begin
    bus_idle_event = 1'b0;
    bus_activity = 1'b0;
    token_valid = 1'b0;
    token_addr = 7'h55;
  end
  // One-cycle pulse on the idle line (idle=1) or the activity line.
  task pulse(input bit idle);
    @(posedge core_clk);
    if (idle) begin
      bus_idle_event <= 1'b1;
    end else begin
      bus_activity <= 1'b1;
    end
    @(posedge core_clk);
    bus_idle_event <= 1'b0;
    bus_activity <= 1'b0;
  endtask : pulse
  // A token carries the address given out earlier by the host.
  task token(input logic [6:0] a);
    @(posedge core_clk);
    token_valid <= 1'b1;
    token_addr <= a;
    @(posedge core_clk);
    token_valid <= 1'b0;
    // The field is scrambled outside a token so stale values never match.
    token_addr <= ~a;
  endtask : token
endmodule : link_model
`default_nettype wire

//--- tb/usb_suspend_resume_address_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_link_regs.svh"
module usb_suspend_resume_address_ctrl_test;
  // Bench stimulus and observed outputs.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic host_role = 1'b0;
  logic [31:0] avs_readdata, rd, w;
  logic avs_waitrequest, token_match, resume_drive, suspend_state_flag;
  logic bus_idle_event, bus_activity, token_valid;
  logic [6:0] token_addr, device_function_addr, fa;
  logic [15:0] rx_fifo_byte_addr, tx_fifo_byte_addr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Clock of 8 ns.
  always #4 core_clk = ~core_clk;

  usb_link_ctrl uut (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .host_role, .bus_idle_event, .bus_activity, .token_valid, .token_addr,
    .token_match, .resume_drive, .suspend_state_flag, .device_function_addr,
    .rx_fifo_byte_addr, .tx_fifo_byte_addr);
  link_model link (.core_clk, .bus_idle_event, .bus_activity, .token_valid,
    .token_addr);

  // Expected control status word from its fields.
  function automatic logic [31:0] csr(logic [6:0] f, logic en, sus, res);
    return {21'h0, res, sus, en, 1'b0, f};
  endfunction : csr

  task end_sim;
    $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One Avalon access; held until waitrequest is seen low, then an edge
  // passes so the next access never lands in the same time step.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask : rchk

  // A hang is cut short well past the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    void'($urandom(32'h202a));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rchk("csr0", `CSR0_OFS, 32'h0);
    rchk("fifoa", `FIFOA_OFS, 32'h0);
    bus(1'b1, 4'h8, 32'hffff_ffff);
    rchk("unmapped", 4'h8, 32'h0);
    // FIFO starts: the all-ones corner first, then random words.
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 32'hffff_ffff : $urandom;
      bus(1'b1, `FIFOA_OFS, w);
      chk("tx_byte", 32'(tx_fifo_byte_addr), {w[12:0], 3'h0});
      chk("rx_byte", 32'(rx_fifo_byte_addr), {w[28:16], 3'h0});
      rchk("fifoa", `FIFOA_OFS, w & 32'h1fff_1fff);
    end
    // Low lanes only: the transmit start clears, the receive start stays.
    avs_byteenable <= 4'h3;
    bus(1'b1, `FIFOA_OFS, 32'h0);
    avs_byteenable <= 4'hf;
    rchk("fifoa_lanes", `FIFOA_OFS, w & 32'h1fff_0000);
    // Function address with the spare bit written as one, then tokens.
    for (int i = 0; i < 4; i++) begin
      fa = 7'($urandom);
      bus(1'b1, `CSR0_OFS, {24'h0, 1'b1, fa});
      chk("device_function_addr", 32'(device_function_addr), 32'(fa));
      rchk("csr0", `CSR0_OFS, csr(fa, 1'b0, 1'b0, 1'b0));
      link.token(fa);
      @(posedge core_clk);
      chk("match", 32'(token_match), 32'h1);
      link.token(fa ^ 7'h40);
      @(posedge core_clk);
      chk("nomatch", 32'(token_match), 32'h0);
    end
    // Idle is ignored while suspend is disabled, taken once enabled.
    link.pulse(1'b1);
    rchk("csr0", `CSR0_OFS, csr(fa, 1'b0, 1'b0, 1'b0));
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b0, 1'b0));
    link.pulse(1'b1);
    rchk("csr0", `CSR0_OFS, csr(fa, 1'b1, 1'b1, 1'b0));
    chk("flag", 32'(suspend_state_flag), 32'h1);
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b0, 1'b0));
    rchk("csr0", `CSR0_OFS, csr(fa, 1'b1, 1'b1, 1'b0));
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b0, 1'b1));
    @(posedge core_clk);
    chk("resume", 32'(resume_drive), 32'h1);
    link.pulse(1'b0);
    @(posedge core_clk);
    chk("flag", 32'(suspend_state_flag), 32'h1);
    // The block times nothing itself, so the software hold is shortened.
    repeat (20) @(posedge core_clk);
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b0, 1'b0));
    @(posedge core_clk);
    chk("resume", 32'(resume_drive), 32'h0);
    chk("flag", 32'(suspend_state_flag), 32'h0);
    // Far-end activity ends a suspend.
    link.pulse(1'b1);
    @(posedge core_clk);
    chk("flag", 32'(suspend_state_flag), 32'h1);
    link.pulse(1'b0);
    @(posedge core_clk);
    chk("flag", 32'(suspend_state_flag), 32'h0);
    // A device-role write of one to the status bit must be ignored.
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b1, 1'b0));
    rchk("csr0", `CSR0_OFS, csr(fa, 1'b1, 1'b0, 1'b0));
    // Host role: software enters suspend, resume end clears it.
    host_role <= 1'b1;
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b1, 1'b0));
    rchk("csr0", `CSR0_OFS, csr(fa, 1'b1, 1'b1, 1'b0));
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b1, 1'b1));
    chk("hresume", 32'(resume_drive), 32'h1);
    repeat (20) @(posedge core_clk);
    bus(1'b1, `CSR0_OFS, csr(fa, 1'b1, 1'b0, 1'b0));
    @(posedge core_clk);
    chk("flag", 32'(suspend_state_flag), 32'h0);
    link.token(fa);
    @(posedge core_clk);
    chk("hostmatch", 32'(token_match), 32'h0);
    end_sim;
  end
endmodule : usb_suspend_resume_address_ctrl_test
`default_nettype wire
